// >>> core/ufc_top.sv
// Purpose: Serial port flow control, receive errors and interrupts.
// Assumes: Shifters and DMA engine share CORE_CLK; CTS_N is a pin.
// Notes: Registers sit on an AHB-Lite slave with zero wait states.
// What this block does
// RULE1: Flow on: start a character only with CTS.
// RULE2: CTS loss mid-character finishes the character.
// RULE3: Auto mode: RTS asserted while room for two.
// RULE4: Software mode: RTS follows a configuration bit.
// RULE5: Flow off: RTS and CTS are ignored.
// RULE6: DMA pop records offset of first bad character.
// RULE7: Overrun offset recorded four characters ahead.
// RULE8: Overrun raises interrupt and DMA status at once.
// RULE9: DMA reset or buffer reload clears error.
// RULE10: Transmit idle interrupt, edge or level mode.
// RULE11: Transmit space interrupt, edge or level mode.
// RULE12: Receive available interrupt, edge or level mode.
// RULE13: DMA buffer done interrupt on active fall.
// RULE14: Parity, frame and overrun errors interrupt.
// RULE15: Interrupt needs source enable and top enable.
// RULE16: Four-deep FIFOs fed and drained by data register.
// RULE17: Idle flag when FIFO and shifter are empty.
// RULE18: Overrun flag set on full, cleared by read.
// RULE19: Error flags describe head character, clear when empty.
// RULE20: Software RTS bit one drives the pin low.
// RULE21: Partner stops sending soon after RTS rises.
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module ufc_top import ufc_pkg::*; (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic CTS_N,
    output logic RTS_N,
    output logic TX_START,
    output logic [7:0] TX_DATA,
    input wire logic TX_DONE,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_PAR_ERR,
    input wire logic RX_FRM_ERR,
    input wire logic RXDMA_POP,
    input wire logic RXDMA_BUF,
    input wire logic [15:0] RXDMA_OFFSET,
    input wire logic [1:0] RXDMA_LOAD,
    input wire logic [1:0] TXDMA_ACT,
    input wire logic [1:0] RXDMA_ACT,
    output logic [CFG_W-1:0] CFG_OUT,
    output logic IRQ
);
    ufc_fifo_if #(.W(8)) txf();
    ufc_fifo_if #(.W(10)) rxf();

    ufc_fifo #(.W(8)) u_txf (.clk(CORE_CLK), .srst(SRST), .f(txf));
    ufc_fifo #(.W(10)) u_rxf (.clk(CORE_CLK), .srst(SRST), .f(rxf));

    logic [CFG_W-1:0] cfg_q;
    logic [IRQ_W-1:0] irq_en_q;
    logic [IRQ_W-1:0] irq_flag_q;
    logic irq_mode_q;
    logic top_en_q;
    logic ap_wr_q;
    logic [7:0] ap_addr_q;
    logic cts_s1_q;
    logic cts_s2_q;
    logic tx_busy_q;
    logic ovf_q;
    logic [1:0] err_v_q;
    logic [OFS_W-1:0] rxerr_q [2];
    logic [2:0] lvl_prev_q;
    logic [1:0] txact_prev_q;
    logic [1:0] rxact_prev_q;
    logic [31:0] rd_mux;
    logic [31:0] status;
    logic [2:0] lvl;
    logic [IRQ_W-1:0] ev;
    logic ap_valid;
    logic rd_data_pop;
    logic wr_data;
    logic tx_go;
    logic cts_ok;
    logic ovf_evt;
    logic head_err;
    logic dma_err_evt;

    // Bus slave: zero wait states, always OKAY, whole-word access only.
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign ap_valid = HSEL && HTRANS[1] && HREADY;
    assign rd_data_pop = ap_valid && !HWRITE && (HADDR[7:0] == A_DATA);
    assign wr_data = ap_wr_q && (ap_addr_q == A_DATA);

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            ap_wr_q <= 1'b0;
            ap_addr_q <= 8'h00;
        end else begin
            ap_wr_q <= ap_valid && HWRITE;
            if (ap_valid) begin
                ap_addr_q <= HADDR[7:0];
            end
        end
    end

    // Read data is captured in the address phase so it stands in the data
    // phase; a data read therefore pops the receive FIFO at that edge.
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            HRDATA <= 32'h00000000;
        end else if (ap_valid && !HWRITE) begin
            HRDATA <= rd_mux;
        end
    end

    always_comb begin
        status = 32'h00000000;
        status[ST_CTS] = cts_ok;
        status[ST_RXVAL] = !rxf.empty;
        status[ST_TXFREE] = !txf.full;
        status[ST_RXOVF] = ovf_q;
        status[ST_FRM] = !rxf.empty && rxf.rdata[9]; // RULE19
        status[ST_PAR] = !rxf.empty && rxf.rdata[8]; // RULE19
        status[ST_TXIDLE] = txf.empty && !tx_busy_q; // RULE17
    end

    always_comb begin
        rd_mux = 32'h00000000;
        case (HADDR[7:0])
            A_DATA: rd_mux = {24'h000000, rxf.rdata[7:0]};
            A_STATUS: rd_mux = status;
            A_CONFIG: rd_mux = {25'h0000000, cfg_q};
            A_IRQ_EN: rd_mux = {22'h000000, irq_en_q};
            A_IRQ_FLAG: rd_mux = {22'h000000, irq_flag_q};
            A_IRQ_MODE: rd_mux = {31'h00000000, irq_mode_q};
            A_RXERR_A: rd_mux = {16'h0000, rxerr_q[0]};
            A_RXERR_B: rd_mux = {16'h0000, rxerr_q[1]};
            A_DMA_STAT: rd_mux = {30'h00000000, err_v_q};
            A_TOP_EN: rd_mux = {31'h00000000, top_en_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            cfg_q <= CFG_RST;
            irq_en_q <= IRQ_RST;
            irq_mode_q <= 1'b0;
            top_en_q <= 1'b0;
        end else if (ap_wr_q) begin
            case (ap_addr_q)
                A_CONFIG: cfg_q <= HWDATA[CFG_W-1:0];
                A_IRQ_EN: irq_en_q <= HWDATA[IRQ_W-1:0];
                A_IRQ_MODE: irq_mode_q <= HWDATA[0];
                A_TOP_EN: top_en_q <= HWDATA[0];
                default: cfg_q <= cfg_q;
            endcase
        end
    end
    assign CFG_OUT = cfg_q;

    // The pin is asynchronous; nothing reads the first stage directly.
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            cts_s1_q <= 1'b1;
            cts_s2_q <= 1'b1;
        end else begin
            cts_s1_q <= CTS_N;
            cts_s2_q <= cts_s1_q;
        end
    end
    assign cts_ok = !cts_s2_q;

    // Transmit: CTS is looked at only when a character would start, so a
    // character already shifting always completes.
    assign tx_go = !txf.empty && !tx_busy_q
                   && (!cfg_q[CFG_FLOW] || cts_ok); // RULE1 RULE5
    assign txf.push = wr_data; // RULE16
    assign txf.wdata = HWDATA[7:0];
    assign txf.pop = tx_go;

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            tx_busy_q <= 1'b0;
            TX_START <= 1'b0;
            TX_DATA <= 8'h00;
        end else begin
            TX_START <= tx_go;
            if (tx_go) begin
                tx_busy_q <= 1'b1;
                TX_DATA <= txf.rdata;
            end else if (TX_DONE) begin
                tx_busy_q <= 1'b0; // RULE2
            end
        end
    end

    // Receive path; error bits travel with each character.
    assign rxf.push = RX_VALID;
    assign rxf.wdata = {RX_FRM_ERR, RX_PAR_ERR, RX_DATA};
    assign rxf.pop = rd_data_pop || RXDMA_POP; // RULE16
    assign ovf_evt = RX_VALID && rxf.full;
    assign head_err = !rxf.empty && (rxf.rdata[8] || rxf.rdata[9]);
    assign dma_err_evt = RXDMA_POP && head_err;

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            ovf_q <= 1'b0;
        end else if (ovf_evt) begin
            ovf_q <= 1'b1; // RULE18
        end else if (rd_data_pop) begin
            ovf_q <= 1'b0; // RULE18
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            RTS_N <= 1'b1;
        end else if (!cfg_q[CFG_FLOW]) begin
            RTS_N <= 1'b1; // RULE5
        end else if (cfg_q[CFG_AUTO]) begin
            RTS_N <= (rxf.count > RTS_ROOM2_MAX_CNT); // RULE3
        end else begin
            RTS_N <= !cfg_q[CFG_RTS]; // RULE4 RULE20
        end
    end

    // Error offsets per DMA buffer; a new error beats a clear.
    for (genvar b = 0; b < 2; b++) begin : g_rxerr
        logic hit;
        logic clr;
        assign hit = (RXDMA_BUF == 1'(b)) && (dma_err_evt || ovf_evt);
        assign clr = (ap_wr_q && (ap_addr_q == A_DMA_CTRL) && HWDATA[b])
                     || RXDMA_LOAD[b]; // RULE9
        always_ff @(posedge CORE_CLK) begin
            if (SRST) begin
                err_v_q[b] <= 1'b0;
                rxerr_q[b] <= OFS_RST;
            end else if (hit && !err_v_q[b]) begin
                err_v_q[b] <= 1'b1; // RULE6 RULE8
                rxerr_q[b] <= dma_err_evt ? RXDMA_OFFSET
                              : RXDMA_OFFSET + OVF_OFS_AHEAD; // RULE6 RULE7
            end else if (clr && !hit) begin
                err_v_q[b] <= 1'b0; // RULE9
            end
        end
    end

    // Interrupt sources.
    assign lvl = {status[ST_TXIDLE], status[ST_TXFREE], status[ST_RXVAL]};

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            lvl_prev_q <= 3'h6;
            txact_prev_q <= 2'h0;
            rxact_prev_q <= 2'h0;
        end else begin
            lvl_prev_q <= lvl;
            txact_prev_q <= TXDMA_ACT;
            rxact_prev_q <= RXDMA_ACT;
        end
    end

    always_comb begin
        ev = IRQ_RST;
        for (int i = 0; i < 3; i++) begin
            ev[IRQ_RXVAL + i] = irq_mode_q ? lvl[i]
                                : (lvl[i] && !lvl_prev_q[i]); // RULE10 RULE11 RULE12
        end
        ev[IRQ_RXOVF] = ovf_evt; // RULE8 RULE14
        ev[IRQ_PAR] = RX_VALID && RX_PAR_ERR; // RULE14
        ev[IRQ_FRM] = RX_VALID && RX_FRM_ERR; // RULE14
        ev[IRQ_TXDMA +: 2] = txact_prev_q & ~TXDMA_ACT; // RULE13
        ev[IRQ_RXDMA +: 2] = rxact_prev_q & ~RXDMA_ACT; // RULE13
    end

    // Write one to clear; a source firing in the same cycle stays set.
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            irq_flag_q <= IRQ_RST;
        end else if (ap_wr_q && (ap_addr_q == A_IRQ_FLAG)) begin
            irq_flag_q <= (irq_flag_q & ~HWDATA[IRQ_W-1:0]) | ev;
        end else begin
            irq_flag_q <= irq_flag_q | ev;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= top_en_q && |(irq_flag_q & irq_en_q); // RULE15
        end
    end

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (SRST);

    chk_tx_cts_gate: assert property ( // RULE1
        tx_go && cfg_q[CFG_FLOW] |-> !cts_s2_q)
        else $error("Character started without CTS.");
    chk_tx_finish: assert property ( // RULE2
        tx_busy_q && !TX_DONE |=> tx_busy_q && !TX_START)
        else $error("Transmit interrupted or overlapped.");
    chk_rts_auto_room: assert property ( // RULE3
        cfg_q[CFG_FLOW] && cfg_q[CFG_AUTO]
        |=> RTS_N == ($past(rxf.count) > 3'h2))
        else $error("Automatic RTS level wrong.");
    chk_rts_sw_level: assert property ( // RULE4
        cfg_q[CFG_FLOW] && !cfg_q[CFG_AUTO]
        |=> RTS_N == !$past(cfg_q[CFG_RTS]))
        else $error("Software RTS level wrong.");
    chk_rts_flow_off: assert property ( // RULE5
        !cfg_q[CFG_FLOW] |=> RTS_N)
        else $error("RTS asserted with flow control off.");
    chk_dma_err_rec: assert property ( // RULE6
        dma_err_evt && !RXDMA_BUF && !err_v_q[0]
        |=> err_v_q[0] && rxerr_q[0] == $past(RXDMA_OFFSET))
        else $error("Receive error offset not recorded.");
    chk_ovf_offset: assert property ( // RULE7
        ovf_evt && !dma_err_evt && RXDMA_BUF && !err_v_q[1]
        |=> rxerr_q[1] == $past(RXDMA_OFFSET) + 16'h0004)
        else $error("Overrun offset not four ahead.");
    chk_ovf_immediate: assert property ( // RULE8
        ovf_evt |=> irq_flag_q[IRQ_RXOVF] && ovf_q
        && err_v_q[$past(RXDMA_BUF)])
        else $error("Overrun not flagged at once.");
    chk_buf_done_irq: assert property ( // RULE13
        $fell(RXDMA_ACT[0]) |=> irq_flag_q[IRQ_RXDMA])
        else $error("Buffer done interrupt missing.");
    chk_irq_gate: assert property ( // RULE15
        IRQ |-> $past(top_en_q) && |($past(irq_flag_q & irq_en_q)))
        else $error("Interrupt raised while disabled.");
    chk_idle_flag: assert property ( // RULE17
        status[ST_TXIDLE] |-> txf.empty && !tx_busy_q && !TX_START)
        else $error("Idle flag with data pending.");

    cov_flow_start: cover property (cfg_q[CFG_FLOW] && tx_go);
    cov_overrun: cover property (ovf_evt);
    cov_dma_err: cover property (dma_err_evt);
    cov_irq_out: cover property ($rose(IRQ));
endmodule // ufc_top

// >>> core/ufc_pkg.sv
// Purpose: Shared constants of the serial flow-control and error block.
// Assumes: One 32-bit AHB-Lite slave, byte addresses in the low byte.
// Notes: Offsets and bit positions are used by name in the block; the bench uses literal masks.
package ufc_pkg;
    localparam int FIFO_DEPTH = 4;
    localparam int PTR_W = 2;
    localparam int CNT_W = 3;
    localparam int OFS_W = 16;
    localparam int CFG_W = 7;
    localparam int IRQ_W = 10;
    localparam logic [PTR_W-1:0] PTR_LAST = 2'h3;
    localparam logic [CNT_W-1:0] CNT_FULL = 3'h4;
    // Receive count at or below this leaves room for two characters.
    localparam logic [CNT_W-1:0] RTS_ROOM2_MAX_CNT = 3'h2;
    // An overrun is recorded this many characters beyond the DMA offset.
    localparam logic [OFS_W-1:0] OVF_OFS_AHEAD = 16'h0004;
    // Register byte offsets.
    localparam logic [7:0] A_DATA = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_CONFIG = 8'h08;
    localparam logic [7:0] A_IRQ_EN = 8'h0C;
    localparam logic [7:0] A_IRQ_FLAG = 8'h10;
    localparam logic [7:0] A_IRQ_MODE = 8'h14;
    localparam logic [7:0] A_DMA_CTRL = 8'h18;
    localparam logic [7:0] A_RXERR_A = 8'h1C;
    localparam logic [7:0] A_RXERR_B = 8'h20;
    localparam logic [7:0] A_DMA_STAT = 8'h24;
    localparam logic [7:0] A_TOP_EN = 8'h28;
    // Configuration bits.
    localparam int CFG_RTS = 0;
    localparam int CFG_8BIT = 1;
    localparam int CFG_FLOW = 5;
    localparam int CFG_AUTO = 6;
    // Status bits.
    localparam int ST_CTS = 0;
    localparam int ST_RXVAL = 1;
    localparam int ST_TXFREE = 2;
    localparam int ST_RXOVF = 3;
    localparam int ST_FRM = 4;
    localparam int ST_PAR = 5;
    localparam int ST_TXIDLE = 6;
    // Interrupt source bits.
    localparam int IRQ_RXVAL = 0;
    localparam int IRQ_TXFREE = 1;
    localparam int IRQ_TXIDLE = 2;
    localparam int IRQ_RXOVF = 3;
    localparam int IRQ_PAR = 4;
    localparam int IRQ_FRM = 5;
    localparam int IRQ_TXDMA = 6;
    localparam int IRQ_RXDMA = 8;
    // Values after reset; STATUS_RST is unused, the status register reads 32'h00000044.
    localparam logic [CFG_W-1:0] CFG_RST = 7'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST = 10'h000;
    localparam logic [OFS_W-1:0] OFS_RST = 16'h0000;
    localparam logic [31:0] STATUS_RST = 32'h00000040;
endpackage

// >>> core/ufc_fifo_if.sv
// Purpose: Signals between the block and one character FIFO.
// Assumes: Push and pop are single-cycle requests.
// Notes: Width is set per instance.
`timescale 1ns/1ps
interface ufc_fifo_if import ufc_pkg::*; #(parameter int W = 8);
    logic push;
    logic [W-1:0] wdata;
    logic pop;
    logic [W-1:0] rdata;
    logic full;
    logic empty;
    logic [CNT_W-1:0] count;
    modport store(input push, input wdata, input pop,
                  output rdata, output full, output empty, output count);
    modport user(output push, output wdata, output pop,
                 input rdata, input full, input empty, input count);
endinterface

// >>> core/ufc_fifo.sv
// Purpose: Four-entry character FIFO in flip-flops.
// Assumes: Push when full and pop when empty are ignored.
// Notes: Head entry is visible on rdata without a pop.
`timescale 1ns/1ps
module ufc_fifo import ufc_pkg::*; #(parameter int W = 8) (
    input wire logic clk,
    input wire logic srst,
    ufc_fifo_if.store f
);
    logic [W-1:0] mem_q [FIFO_DEPTH];
    logic [PTR_W-1:0] wp_q;
    logic [PTR_W-1:0] rp_q;
    logic [CNT_W-1:0] cnt_q;
    logic do_push;
    logic do_pop;

    assign do_push = f.push && (cnt_q != CNT_FULL);
    assign do_pop = f.pop && (cnt_q != '0);

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_q[wp_q] <= f.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wp_q <= (wp_q == PTR_LAST) ? '0 : wp_q + 2'h1;
            end
            if (do_pop) begin
                rp_q <= (rp_q == PTR_LAST) ? '0 : rp_q + 2'h1;
            end
            if (do_push && !do_pop) begin
                cnt_q <= cnt_q + 3'h1;
            end else if (do_pop && !do_push) begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end

    assign f.rdata = mem_q[rp_q];
    assign f.full = (cnt_q == CNT_FULL);
    assign f.empty = (cnt_q == '0);
    assign f.count = cnt_q;
endmodule // ufc_fifo

// >>> testbench/ufc_link_model.sv
// Purpose: Far-side model: shifters plus the external serial device.
// Assumes: One character per TX_START, finished TX_CYC cycles later.
// Notes: Idle receive lines toggle so stale data is never trusted.
`timescale 1ns/1ps
module ufc_link_model #(parameter int TX_CYC = 12) (
    input wire logic clk,
    input wire logic srst,
    input wire logic tx_start,
    input wire logic [7:0] tx_data,
    input wire logic rts_n,
    input wire logic obey_rts,
    input wire logic send,
    input wire logic [9:0] snd,
    output logic tx_done,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_par,
    output logic rx_frm,
    output logic [7:0] last_tx,
    output logic [7:0] starts
);
    int cnt;
    always_ff @(posedge clk) begin
        tx_done <= 1'b0;
        rx_valid <= 1'b0;
        if (srst) begin
            cnt <= 0;
            starts <= 8'h00;
            last_tx <= 8'h00;
            {rx_par, rx_frm, rx_data} <= 10'h000;
        end else begin
            if (tx_start) begin
                cnt <= TX_CYC;
                last_tx <= tx_data;
                starts <= starts + 8'h01;
            end else if (cnt == 1) begin
                tx_done <= 1'b1;
                cnt <= 0;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
            // A sender that obeys RTS is only modelled when asked for.
            if (send && !(obey_rts && rts_n)) begin
                rx_valid <= 1'b1;
                {rx_par, rx_frm, rx_data} <= snd;
            end else begin
                {rx_par, rx_frm, rx_data} <= ~{rx_par, rx_frm, rx_data};
            end
        end
    end
endmodule // ufc_link_model

// >>> testbench/uart_flow_ctrl_rx_errors_irq_bench.sv
// Purpose: Self-checking bench of the flow-control and error block.
// Assumes: Zero-wait AHB-Lite slave; far side is ufc_link_model.
// Notes: Fixed settle delays cover the flag and interrupt latencies.
`timescale 1ns/1ps
module uart_flow_ctrl_rx_errors_irq_bench import ufc_pkg::*;;
    localparam int TXC = 12;
    logic clk, srst, hsel, hwrite, cts_n, send, obey, pop, rbuf;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans, rload, tact, ract;
    logic [2:0] hsize;
    logic [9:0] snd;
    logic [15:0] rofs;
    logic [7:0] tx_data, rx_data, last_tx, starts;
    logic [CFG_W-1:0] cfg_out;
    logic hready, hresp, rts_n, tx_start, tx_done, rx_valid, rx_par, rx_frm;
    logic irq;
    int error_cnt = 0;
    int num_checks = 0;
    ufc_top dut_u(.CORE_CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .CTS_N(cts_n), .RTS_N(rts_n), .TX_START(tx_start),
        .TX_DATA(tx_data), .TX_DONE(tx_done), .RX_VALID(rx_valid),
        .RX_DATA(rx_data), .RX_PAR_ERR(rx_par), .RX_FRM_ERR(rx_frm),
        .RXDMA_POP(pop), .RXDMA_BUF(rbuf), .RXDMA_OFFSET(rofs),
        .RXDMA_LOAD(rload), .TXDMA_ACT(tact), .RXDMA_ACT(ract),
        .CFG_OUT(cfg_out), .IRQ(irq));
    ufc_link_model #(.TX_CYC(TXC)) link_u(.clk(clk), .srst(srst),
        .tx_start(tx_start), .tx_data(tx_data), .rts_n(rts_n),
        .obey_rts(obey), .send(send), .snd(snd), .tx_done(tx_done),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_par(rx_par),
        .rx_frm(rx_frm), .last_tx(last_tx), .starts(starts));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic tally_and_finish;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic hang;
        $display("Error at %0t: wait timed out", $time);
        error_cnt++;
        tally_and_finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) hang;
    endtask
    // Read data is taken at the edge that closes the data phase.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdm(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        check(q & m, e);
    endtask
    task automatic rx(input logic [7:0] b, input logic p, input logic f);
        send <= 1'b1;
        snd <= {p, f, b};
        @(posedge clk);
        send <= 1'b0;
        ticks(4);
    endtask
    task automatic wait_starts(input logic [7:0] n);
        int i;
        for (i = 0; i < 400 && starts !== n; i++) @(posedge clk);
        if (starts !== n) hang;
    endtask
    task automatic t_reset;
        rdm(A_STATUS, 32'hFFFFFFFF, 32'h00000044);
        rdm(A_CONFIG, 32'hFFFFFFFF, 32'h00000000);
        rdm(8'h30, 32'hFFFFFFFF, 32'h00000000);
        check(rts_n, 1'b1);
        check(irq, 1'b0);
        check(hresp, 1'b0);
    endtask
    task automatic t_rts;
        int i;
        wr(A_CONFIG, 32'h01);
        ticks(3);
        check(rts_n, 1'b1);
        check(cfg_out, 32'h01);
        wr(A_CONFIG, 32'h21);
        ticks(3);
        check(rts_n, 1'b0);
        wr(A_CONFIG, 32'h20);
        ticks(3);
        check(rts_n, 1'b1);
        wr(A_CONFIG, 32'h60);
        obey <= 1'b1;
        for (i = 0; i < 3; i++) begin
            ticks(3);
            check(rts_n, 1'b0);
            rx(8'h10 + i, 1'b0, 1'b0);
        end
        check(rts_n, 1'b1);
        rx(8'hEE, 1'b0, 1'b0);
        obey <= 1'b0;
        rx(8'h13, 1'b0, 1'b0);
        rx(8'h14, 1'b0, 1'b0);
        rdm(A_STATUS, 32'hFFFFFFFF, 32'h0000004E);
        rdm(A_IRQ_FLAG, 32'h00000008, 32'h00000008);
        rdm(A_DMA_STAT, 32'h00000003, 32'h00000001);
        rdm(A_RXERR_A, 32'h0000FFFF, 32'h00000004);
        wr(A_DMA_CTRL, 32'h1);
        rdm(A_DMA_STAT, 32'h00000003, 32'h00000000);
        for (i = 0; i < 4; i++) begin
            rdm(A_DATA, 32'h000000FF, 32'h10 + i);
            rdm(A_STATUS, 32'h00000008, 32'h00000000);
        end
        rdm(A_STATUS, 32'hFFFFFFFF, 32'h00000044);
        check(rts_n, 1'b0);
    endtask
    task automatic t_tx;
        int i;
        wr(A_CONFIG, 32'h20);
        for (i = 0; i < 4; i++) wr(A_DATA, 32'hA0 + i);
        rdm(A_STATUS, 32'hFFFFFFFF, 32'h00000000);
        wr(A_IRQ_FLAG, 32'h3FF);
        ticks(10);
        check(starts, 8'h00);
        cts_n <= 1'b0;
        wait_starts(8'h01);
        cts_n <= 1'b1;
        check(last_tx, 8'hA0);
        ticks(TXC + 20);
        check(starts, 8'h01);
        rdm(A_IRQ_FLAG, 32'h00000002, 32'h00000002);
        cts_n <= 1'b0;
        wait_starts(8'h04);
        ticks(TXC + 20);
        check(last_tx, 8'hA3);
        rdm(A_STATUS, 32'hFFFFFFFF, 32'h00000045);
        rdm(A_IRQ_FLAG, 32'h00000004, 32'h00000004);
        wr(A_CONFIG, 32'h00);
        cts_n <= 1'b1;
        wr(A_DATA, 32'h77);
        wait_starts(8'h05);
        check(last_tx, 8'h77);
        ticks(TXC + 20);
    endtask
    task automatic t_irq;
        wr(A_IRQ_FLAG, 32'h3FF);
        wr(A_IRQ_EN, 32'h001);
        wr(A_TOP_EN, 32'h0);
        rx(8'h21, 1'b0, 1'b0);
        check(irq, 1'b0);
        wr(A_TOP_EN, 32'h1);
        ticks(2);
        check(irq, 1'b1);
        wr(A_IRQ_EN, 32'h000);
        ticks(2);
        check(irq, 1'b0);
        wr(A_IRQ_FLAG, 32'h3FF);
        rdm(A_IRQ_FLAG, 32'h00000005, 32'h00000000);
        wr(A_IRQ_MODE, 32'h1);
        wr(A_IRQ_FLAG, 32'h3FF);
        rdm(A_IRQ_FLAG, 32'h00000005, 32'h00000005);
        wr(A_IRQ_MODE, 32'h0);
        rdm(A_DATA, 32'h000000FF, 32'h00000021);
    endtask
    task automatic t_dma;
        int i;
        wr(A_IRQ_FLAG, 32'h3FF);
        rofs <= 16'h0005;
        rx(8'h33, 1'b1, 1'b0);
        rdm(A_STATUS, 32'hFFFFFFFF, 32'h00000066);
        rdm(A_IRQ_FLAG, 32'h00000010, 32'h00000010);
        pop <= 1'b1;
        @(posedge clk);
        pop <= 1'b0;
        ticks(2);
        rdm(A_RXERR_A, 32'h0000FFFF, 32'h00000005);
        rdm(A_DMA_STAT, 32'h00000003, 32'h00000001);
        rdm(A_STATUS, 32'hFFFFFFFF, 32'h00000044);
        rofs <= 16'h0006;
        rx(8'h34, 1'b0, 1'b1);
        rdm(A_IRQ_FLAG, 32'h00000020, 32'h00000020);
        rdm(A_STATUS, 32'h00000030, 32'h00000010);
        rdm(A_DATA, 32'h000000FF, 32'h00000034);
        wr(A_DMA_CTRL, 32'h1);
        rdm(A_DMA_STAT, 32'h00000003, 32'h00000000);
        rbuf <= 1'b1;
        rofs <= 16'h0010;
        for (i = 0; i < 5; i++) rx(8'h40 + i, 1'b0, 1'b0);
        rdm(A_DMA_STAT, 32'h00000003, 32'h00000002);
        rdm(A_RXERR_B, 32'h0000FFFF, 32'h00000014);
        rload <= 2'h2;
        @(posedge clk);
        rload <= 2'h0;
        rdm(A_DMA_STAT, 32'h00000003, 32'h00000000);
        for (i = 0; i < 4; i++) rdm(A_DATA, 32'h000000FF, 32'h40 + i);
        // Each done flag must come from its own falling active flag.
        for (i = 0; i < 4; i++) begin
            wr(A_IRQ_FLAG, 32'h3FF);
            {ract, tact} <= 4'h1 << i;
            ticks(3);
            {ract, tact} <= 4'h0;
            ticks(3);
            rdm(A_IRQ_FLAG, 32'h000003C0, 32'h40 << i);
        end
    endtask
    initial begin
        #700000;
        hang;
    end
    initial begin
        srst = 1'b1;
        {hsel, hwrite, cts_n, send, obey, pop, rbuf} = 7'h10;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        snd = 10'h000;
        rofs = 16'h0000;
        {rload, tact, ract} = 6'h00;
        ticks(6);
        srst <= 1'b0;
        t_reset;
        t_rts;
        t_tx;
        t_irq;
        t_dma;
        tally_and_finish;
    end
endmodule // uart_flow_ctrl_rx_errors_irq_bench
